// File: include/cip_pkg.sv
// types of the camera sensor input port
package cip_pkg;

  typedef enum logic [1:0] {
    CIP_MODE_EMBEDDED = 2'b00,
    CIP_MODE_GATED    = 2'b01,
    CIP_MODE_FREE     = 2'b10,
    CIP_MODE_NONE     = 2'b11
  } cip_mode_type;

endpackage

// File: include/cip_regs.svh
// constants of the camera sensor input port
`ifndef CIP_REGS_SVH
`define CIP_REGS_SVH

`define CIP_DATA_W        8
`define CIP_WORD_W        10
`define CIP_FIFO_AW       4
`define CIP_CFG_W         4
`define CIP_WORD_SOF_BIT  9
`define CIP_WORD_SOL_BIT  8
`define CIP_CODE_LEAD     8'hFF
`define CIP_CODE_ZERO     8'h00
`define CIP_XY_V_BIT      5
`define CIP_XY_H_BIT      4
`define CIP_CFG_MODE_HI   3
`define CIP_CFG_MODE_LO   2
`define CIP_CFG_FS_BIT    1
`define CIP_CFG_LS_BIT    0
`define CIP_CFG_RST       4'h0

`endif

// File: logic/cip_async_fifo.sv
// dual-clock fifo with gray-coded pointers
`timescale 1ns/1ps
`include "cip_regs.svh"

module cip_async_fifo #(
  parameter int W  = `CIP_WORD_W,
  parameter int AW = `CIP_FIFO_AW
) (
  input  wire logic         wr_clk,
  input  wire logic         wr_rst_n,
  input  wire logic         wr_en,
  input  wire logic [W-1:0] wr_data,
  output logic              wr_full,
  input  wire logic         rd_clk,
  input  wire logic         rd_rst_n,
  input  wire logic         rd_en,
  output logic      [W-1:0] rd_data,
  output logic              rd_empty
);

  logic [W-1:0] mem [0:(1<<AW)-1];
  logic [AW:0]  wbin_r;
  logic [AW:0]  wgray_r;
  logic [AW:0]  rbin_r;
  logic [AW:0]  rgray_r;
  logic [AW:0]  rq1_r;
  logic [AW:0]  rq2_r;
  logic [AW:0]  wq1_r;
  logic [AW:0]  wq2_r;
  logic [AW:0]  wbin_nxt;
  logic [AW:0]  wgray_nxt;
  logic [AW:0]  rbin_nxt;
  logic [AW:0]  rgray_nxt;
  logic         push;
  logic         pop;

  assign push      = wr_en & ~wr_full;
  assign pop       = rd_en & ~rd_empty;
  assign wbin_nxt  = wbin_r + {{AW{1'b0}}, push};
  assign rbin_nxt  = rbin_r + {{AW{1'b0}}, pop};
  assign wgray_nxt = (wbin_nxt >> 1) ^ wbin_nxt;
  assign rgray_nxt = (rbin_nxt >> 1) ^ rbin_nxt;
  assign rd_data   = mem[rbin_r[AW-1:0]];

  always_ff @(posedge wr_clk) begin
    if (push) begin
      mem[wbin_r[AW-1:0]] <= wr_data;
    end
  end

  // ----------------------------------------------------------------
  // write side
  // ----------------------------------------------------------------
  always_ff @(posedge wr_clk or negedge wr_rst_n) begin
    if (!wr_rst_n) begin
      wbin_r  <= '0;
      wgray_r <= '0;
      rq1_r   <= '0;
      rq2_r   <= '0;
      wr_full <= 1'b0;
    end else begin
      wbin_r  <= wbin_nxt;
      wgray_r <= wgray_nxt;
      rq1_r   <= rgray_r;
      rq2_r   <= rq1_r;
      wr_full <= wgray_nxt == {~rq2_r[AW:AW-1], rq2_r[AW-2:0]};
    end
  end

  // ----------------------------------------------------------------
  // read side
  // ----------------------------------------------------------------
  always_ff @(posedge rd_clk or negedge rd_rst_n) begin
    if (!rd_rst_n) begin
      rbin_r   <= '0;
      rgray_r  <= '0;
      wq1_r    <= '0;
      wq2_r    <= '0;
      rd_empty <= 1'b1;
    end else begin
      rbin_r   <= rbin_nxt;
      rgray_r  <= rgray_nxt;
      wq1_r    <= wgray_r;
      wq2_r    <= wq1_r;
      rd_empty <= rgray_nxt == wq2_r;
    end
  end

endmodule

// File: logic/cip_sensor_port.sv
// camera sensor input port: capture on the sensor clock, hand-off to the system clock
`timescale 1ns/1ps
`include "cip_regs.svh"

module cip_sensor_port (
  input  wire logic                   clock,
  input  wire logic                   rst_n,
  input  wire logic                   sensor_sample_clock,
  input  wire logic                   frame_sync_in,
  input  wire logic                   line_sync_in,
  input  wire logic [`CIP_DATA_W-1:0] pixel_data_in,
  input  wire logic [1:0]             timing_mode,
  input  wire logic                   frame_sync_falling,
  input  wire logic                   line_sync_active_low,
  input  wire logic                   sample_edge_invert,
  input  wire logic                   pixel_out_ready,
  input  wire logic                   overflow_clear,
  output logic      [`CIP_DATA_W-1:0] pixel_out,
  output logic                        pixel_out_valid,
  output logic                        pixel_out_frame_start,
  output logic                        pixel_out_line_start,
  output logic                        frame_active,
  output logic                        line_active,
  output logic                        frame_start_pulse,
  output logic                        overflow_flag
);

  // ----------------------------------------------------------------
  // capture clock
  // ----------------------------------------------------------------
  // a clock xor rather than a second capture path; the invert
  // setting must only change while the sensor is stopped
  logic cap_clk;

  assign cap_clk = sensor_sample_clock ^ sample_edge_invert;

  // ----------------------------------------------------------------
  // link-domain reset: asserted at once, released on the link clock
  // ----------------------------------------------------------------
  // needs two sensor clock edges after rst_n rises before capture
  logic lrst_meta_r;
  logic lrst_n_r;

  always_ff @(posedge cap_clk or negedge rst_n) begin
    if (!rst_n) begin
      lrst_meta_r <= 1'b0;
      lrst_n_r    <= 1'b0;
    end else begin
      lrst_meta_r <= 1'b1;
      lrst_n_r    <= lrst_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // configuration into the link domain
  // ----------------------------------------------------------------
  logic [`CIP_CFG_W-1:0]  cfg_in;
  logic [`CIP_CFG_W-1:0]  cfg_meta_r;
  logic [`CIP_CFG_W-1:0]  cfg_r;
  cip_pkg::cip_mode_type  mode;
  logic                   is_emb;
  logic                   is_gated;
  logic                   is_free;

  assign cfg_in = {timing_mode, frame_sync_falling, line_sync_active_low};

  always_ff @(posedge cap_clk or negedge lrst_n_r) begin
    if (!lrst_n_r) begin
      cfg_meta_r <= `CIP_CFG_RST;
      cfg_r      <= `CIP_CFG_RST;
    end else begin
      cfg_meta_r <= cfg_in;
      cfg_r      <= cfg_meta_r;
    end
  end

  assign mode     = cip_pkg::cip_mode_type'(cfg_r[`CIP_CFG_MODE_HI:`CIP_CFG_MODE_LO]);
  assign is_emb   = mode == cip_pkg::CIP_MODE_EMBEDDED;
  assign is_gated = mode == cip_pkg::CIP_MODE_GATED;
  assign is_free  = mode == cip_pkg::CIP_MODE_FREE;

  // ----------------------------------------------------------------
  // sync-line timing (gated and free modes)
  // ----------------------------------------------------------------
  // sync and data pins are sampled on the very edge they belong to;
  // a staging register would strand the last word of a gated line
  logic fs_lvl;
  logic ls_lvl;
  logic fs_prev_r;
  logic ls_prev_r;
  logic frame_on_r;
  logic fs_rise;
  logic ls_rise;

  assign fs_lvl  = frame_sync_in ^ cfg_r[`CIP_CFG_FS_BIT];
  assign ls_lvl  = line_sync_in ^ cfg_r[`CIP_CFG_LS_BIT];
  assign fs_rise = fs_lvl & ~fs_prev_r;
  assign ls_rise = ls_lvl & ~ls_prev_r;

  always_ff @(posedge cap_clk or negedge lrst_n_r) begin
    if (!lrst_n_r) begin
      fs_prev_r  <= 1'b0;
      ls_prev_r  <= 1'b0;
      frame_on_r <= 1'b0;
    end else begin
      fs_prev_r <= fs_lvl;
      ls_prev_r <= ls_lvl;
      if (fs_rise) begin
        frame_on_r <= 1'b1;
      end else if (!fs_lvl) begin
        frame_on_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // embedded timing codes
  // ----------------------------------------------------------------
  // bytes wait three edges so a code preamble can be withdrawn
  // before it reaches the fifo
  logic [`CIP_DATA_W-1:0] hist1_r;
  logic [`CIP_DATA_W-1:0] hist2_r;
  logic [`CIP_DATA_W-1:0] hist3_r;
  logic [2:0]             pv_r;
  logic                   vblank_r;
  logic                   active_r;
  logic                   code_hit;
  logic                   xy_sav;
  logic                   xy_eav;
  logic                   xy_v;
  logic                   emb_frame_start;

  assign code_hit = is_emb && hist3_r == `CIP_CODE_LEAD
                  && hist2_r == `CIP_CODE_ZERO && hist1_r == `CIP_CODE_ZERO;
  assign xy_v     = pixel_data_in[`CIP_XY_V_BIT];
  assign xy_sav   = code_hit & ~pixel_data_in[`CIP_XY_H_BIT];
  assign xy_eav   = code_hit & pixel_data_in[`CIP_XY_H_BIT];
  assign emb_frame_start = xy_sav & ~xy_v & vblank_r;

  always_ff @(posedge cap_clk or negedge lrst_n_r) begin
    if (!lrst_n_r) begin
      hist1_r <= `CIP_CODE_ZERO;
      hist2_r <= `CIP_CODE_ZERO;
      hist3_r <= `CIP_CODE_ZERO;
      pv_r    <= 3'h0;
    end else if (code_hit) begin
      hist1_r <= pixel_data_in;
      hist2_r <= hist1_r;
      hist3_r <= hist2_r;
      pv_r    <= 3'h0;
    end else begin
      hist1_r <= pixel_data_in;
      hist2_r <= hist1_r;
      hist3_r <= hist2_r;
      pv_r    <= {pv_r[1:0], active_r & is_emb};
    end
  end

  always_ff @(posedge cap_clk or negedge lrst_n_r) begin
    if (!lrst_n_r) begin
      vblank_r <= 1'b1;
      active_r <= 1'b0;
    end else if (!is_emb) begin
      vblank_r <= 1'b1;
      active_r <= 1'b0;
    end else if (xy_sav) begin
      vblank_r <= xy_v;
      active_r <= ~xy_v;
    end else if (xy_eav) begin
      vblank_r <= xy_v;
      active_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // frame, line and write decisions
  // ----------------------------------------------------------------
  logic                   frame_start;
  logic                   line_start;
  logic                   frame_int;
  logic                   line_int;
  logic                   wr_want;
  logic [`CIP_DATA_W-1:0] wr_byte;

  always_comb begin
    frame_start = 1'b0;
    line_start  = 1'b0;
    frame_int   = 1'b0;
    line_int    = 1'b0;
    wr_want     = 1'b0;
    wr_byte     = pixel_data_in;
    case (mode)
      cip_pkg::CIP_MODE_EMBEDDED: begin
        frame_start = emb_frame_start;
        line_start  = xy_sav & ~xy_v;
        frame_int   = ~vblank_r;
        line_int    = active_r;
        wr_want     = pv_r[2] & ~code_hit;
        wr_byte     = hist3_r;
      end
      cip_pkg::CIP_MODE_GATED: begin
        frame_start = fs_rise;
        line_start  = ls_rise;
        frame_int   = frame_on_r | fs_rise;
        line_int    = ls_lvl;
        wr_want     = ls_lvl;
      end
      cip_pkg::CIP_MODE_FREE: begin
        frame_start = fs_rise;
        line_start  = fs_rise;
        frame_int   = frame_on_r | fs_rise;
        line_int    = frame_int;
        wr_want     = 1'b1;
      end
      default: begin
        wr_want = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // start marks travel with the first word offered on or after their edge, and are lost with it if the fifo is full
  // ----------------------------------------------------------------
  logic                  pend_sof_r;
  logic                  pend_sol_r;
  logic                  wr_full;
  logic                  wr_drop;
  logic [`CIP_WORD_W-1:0] wr_word;

  assign wr_drop = wr_want & wr_full;
  assign wr_word = {pend_sof_r | frame_start, pend_sol_r | line_start, wr_byte};

  always_ff @(posedge cap_clk or negedge lrst_n_r) begin
    if (!lrst_n_r) begin
      pend_sof_r <= 1'b0;
      pend_sol_r <= 1'b0;
    end else begin
      if (frame_start) begin
        pend_sof_r <= ~wr_want;
      end else if (wr_want) begin
        pend_sof_r <= 1'b0;
      end
      if (line_start) begin
        pend_sol_r <= ~wr_want;
      end else if (wr_want) begin
        pend_sol_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // events and levels leaving the link domain
  // ----------------------------------------------------------------
  logic frame_lvl_r;
  logic line_lvl_r;
  logic fstart_tgl_r;
  logic drop_tgl_r;

  always_ff @(posedge cap_clk or negedge lrst_n_r) begin
    if (!lrst_n_r) begin
      frame_lvl_r  <= 1'b0;
      line_lvl_r   <= 1'b0;
      fstart_tgl_r <= 1'b0;
      drop_tgl_r   <= 1'b0;
    end else begin
      frame_lvl_r  <= frame_int;
      line_lvl_r   <= line_int;
      fstart_tgl_r <= fstart_tgl_r ^ frame_start;
      drop_tgl_r   <= drop_tgl_r ^ wr_drop;
    end
  end

  // ----------------------------------------------------------------
  // input fifo
  // ----------------------------------------------------------------
  logic                   rd_empty;
  logic                   rd_pop;
  logic [`CIP_WORD_W-1:0] rd_word;

  cip_async_fifo #(
    .W  (`CIP_WORD_W),
    .AW (`CIP_FIFO_AW)
  ) u_fifo (
    .wr_clk   (cap_clk),
    .wr_rst_n (lrst_n_r),
    .wr_en    (wr_want),
    .wr_data  (wr_word),
    .wr_full  (wr_full),
    .rd_clk   (clock),
    .rd_rst_n (rst_n),
    .rd_en    (rd_pop),
    .rd_data  (rd_word),
    .rd_empty (rd_empty)
  );

  // ----------------------------------------------------------------
  // system-side synchronisers
  // ----------------------------------------------------------------
  logic [3:0] sys_meta_r;
  logic [3:0] sys_sync_r;
  logic       fstart_prev_r;
  logic       drop_prev_r;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sys_meta_r    <= 4'h0;
      sys_sync_r    <= 4'h0;
      fstart_prev_r <= 1'b0;
      drop_prev_r   <= 1'b0;
    end else begin
      sys_meta_r    <= {drop_tgl_r, fstart_tgl_r, line_lvl_r, frame_lvl_r};
      sys_sync_r    <= sys_meta_r;
      fstart_prev_r <= sys_sync_r[2];
      drop_prev_r   <= sys_sync_r[3];
    end
  end

  // ----------------------------------------------------------------
  // status outputs
  // ----------------------------------------------------------------
  logic frame_active_r;
  logic line_active_r;
  logic frame_start_r;
  logic overflow_r;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      frame_active_r <= 1'b0;
      line_active_r  <= 1'b0;
      frame_start_r  <= 1'b0;
    end else begin
      frame_active_r <= sys_sync_r[0];
      line_active_r  <= sys_sync_r[1];
      frame_start_r  <= sys_sync_r[2] ^ fstart_prev_r;
    end
  end

  // a new drop wins over a clear in the same cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      overflow_r <= 1'b0;
    end else if (sys_sync_r[3] ^ drop_prev_r) begin
      overflow_r <= 1'b1;
    end else if (overflow_clear) begin
      overflow_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // output stage
  // ----------------------------------------------------------------
  logic [`CIP_DATA_W-1:0] pix_r;
  logic                   pix_valid_r;
  logic                   pix_sof_r;
  logic                   pix_sol_r;

  assign rd_pop = ~rd_empty & (~pix_valid_r | pixel_out_ready);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pix_r       <= `CIP_CODE_ZERO;
      pix_valid_r <= 1'b0;
      pix_sof_r   <= 1'b0;
      pix_sol_r   <= 1'b0;
    end else if (rd_pop) begin
      pix_r       <= rd_word[`CIP_DATA_W-1:0];
      pix_valid_r <= 1'b1;
      pix_sof_r   <= rd_word[`CIP_WORD_SOF_BIT];
      pix_sol_r   <= rd_word[`CIP_WORD_SOL_BIT];
    end else if (pixel_out_ready) begin
      pix_valid_r <= 1'b0;
    end
  end

  assign pixel_out             = pix_r;
  assign pixel_out_valid       = pix_valid_r;
  assign pixel_out_frame_start = pix_sof_r;
  assign pixel_out_line_start  = pix_sol_r;
  assign frame_active          = frame_active_r;
  assign line_active           = line_active_r;
  assign frame_start_pulse     = frame_start_r;
  assign overflow_flag         = overflow_r;

endmodule

// File: test/cip_sensor_model.sv
// behavioural camera sensor driving the pixel bus
`timescale 1ns/1ps

module cip_sensor_model (
  output logic       sclk,
  output logic       fs,
  output logic       ls,
  output logic [7:0] data
);
  initial begin
    sclk = 1'b0;
    fs   = 1'b0;
    ls   = 1'b0;
    data = 8'h5A;
  end

  // ----------------------------------------
  // one sample, valid around both clock edges
  // ----------------------------------------
  // the syncs and data are set up before either edge, so capture works in both polarities
  task automatic beat(input logic f, input logic l, input logic [7:0] d);
    fs   = f;
    ls   = l;
    data = d;
    #16 sclk = 1'b1;
    #32 sclk = 1'b0;
    // hold time over: the bus no longer shows the sample
    #16 data = ~d;
  endtask
endmodule

// File: test/cip_sensor_port_properties.sv
// port assertions of the camera sensor input port
`timescale 1ns/1ps
`include "cip_regs.svh"

module cip_sensor_port_properties (
  input wire logic                   clock,
  input wire logic                   rst_n,
  input wire logic                   sensor_sample_clock,
  input wire logic                   pixel_out_ready,
  input wire logic                   overflow_clear,
  input wire logic [`CIP_DATA_W-1:0] pixel_out,
  input wire logic                   pixel_out_valid,
  input wire logic                   pixel_out_frame_start,
  input wire logic                   pixel_out_line_start,
  input wire logic                   frame_active,
  input wire logic                   line_active,
  input wire logic                   frame_start_pulse,
  input wire logic                   overflow_flag
);
  logic       prev_sclk_r;
  logic [3:0] quiet_r;

  // clocks since the sensor clock last moved; nothing new can arrive once it has been still
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prev_sclk_r <= 1'b0;
      quiet_r     <= 4'h0;
    end else begin
      prev_sclk_r <= sensor_sample_clock;
      if (sensor_sample_clock != prev_sclk_r) quiet_r <= 4'h0;
      else if (quiet_r != 4'hF) quiet_r <= quiet_r + 4'h1;
    end
  end

  out_reset_a : assert property (@(posedge clock) !rst_n |-> !pixel_out_valid && !frame_active
    && !line_active && !frame_start_pulse && !overflow_flag) else $error("outputs not idle in reset");
  out_hold_a : assert property (@(posedge clock) disable iff (!rst_n)
    pixel_out_valid && !pixel_out_ready |=> pixel_out_valid && $stable(pixel_out)) else $error("word lost");
  flag_hold_a : assert property (@(posedge clock) disable iff (!rst_n) pixel_out_valid && !pixel_out_ready
    |=> $stable({pixel_out_frame_start, pixel_out_line_start})) else $error("start flags changed");
  start_pair_a : assert property (@(posedge clock) disable iff (!rst_n)
    pixel_out_valid && pixel_out_frame_start |-> pixel_out_line_start) else $error("frame start without line");
  pulse_single_a : assert property (@(posedge clock) disable iff (!rst_n)
    frame_start_pulse |=> !frame_start_pulse) else $error("frame pulse too long");
  ovf_sticky_a : assert property (@(posedge clock) disable iff (!rst_n)
    overflow_flag && !overflow_clear |=> overflow_flag) else $error("overflow flag lost");
  ovf_clear_a : assert property (@(posedge clock) disable iff (!rst_n)
    overflow_clear && quiet_r > 4'h8 |=> !overflow_flag) else $error("overflow flag not cleared");
  valid_cause_a : assert property (@(posedge clock) disable iff (!rst_n)
    $rose(pixel_out_valid) |-> quiet_r < 4'hA) else $error("word without sensor clock");
endmodule

bind cip_sensor_port cip_sensor_port_properties cip_sensor_port_properties_inst (
  .clock(clock), .rst_n(rst_n), .sensor_sample_clock(sensor_sample_clock),
  .pixel_out_ready(pixel_out_ready), .overflow_clear(overflow_clear), .pixel_out(pixel_out),
  .pixel_out_valid(pixel_out_valid), .pixel_out_frame_start(pixel_out_frame_start),
  .pixel_out_line_start(pixel_out_line_start), .frame_active(frame_active), .line_active(line_active),
  .frame_start_pulse(frame_start_pulse), .overflow_flag(overflow_flag)
);

// File: test/cip_sensor_port_test.sv
// self-checking bench of the camera sensor input port
`timescale 1ns/1ps

module cip_sensor_port_test;
  logic       clock;
  logic       rst_n;
  logic       sclk;
  logic       fs;
  logic       ls;
  logic [7:0] din;
  logic [1:0] mode;
  logic       fs_fall;
  logic       ls_low;
  logic       inv;
  logic       ready;
  logic       ovf_clr;
  logic [7:0] pix;
  logic       valid;
  logic       sof;
  logic       sol;
  logic       frame_act;
  logic       line_act;
  logic       fpulse;
  logic       ovf;
  int         failures = 0;
  int         total_checks = 0;
  int         cycles = 0;

  cip_sensor_model cip_sensor_model_inst (.sclk(sclk), .fs(fs), .ls(ls), .data(din));

  cip_sensor_port cip_sensor_port_inst (
    .clock(clock), .rst_n(rst_n), .sensor_sample_clock(sclk), .frame_sync_in(fs), .line_sync_in(ls),
    .pixel_data_in(din), .timing_mode(mode), .frame_sync_falling(fs_fall), .line_sync_active_low(ls_low),
    .sample_edge_invert(inv), .pixel_out_ready(ready), .overflow_clear(ovf_clr), .pixel_out(pix),
    .pixel_out_valid(valid), .pixel_out_frame_start(sof), .pixel_out_line_start(sol),
    .frame_active(frame_act), .line_active(line_act), .frame_start_pulse(fpulse), .overflow_flag(ovf)
  );

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles >= 30000) begin
      failures++;
      end_sim();
    end
  end

  task automatic end_sim();
    if (failures == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic report(input string what);
    failures++;
    $display("Error at %0t: %s (word %h valid %b frame %b overflow %b)", $time, what, pix, valid, sof, ovf);
  endtask

  // ----------------------------------------
  // shared steps
  // ----------------------------------------
  task automatic check(input logic [7:0] b, input logic f);
    for (int i = 0; i < 60 && valid !== 1'b1; i++) @(negedge clock);
    total_checks++;
    if (valid !== 1'b1 || pix !== b || sof !== f) report($sformatf("expected word %h frame %b", b, f));
    @(negedge clock);
  endtask

  task automatic check_empty();
    repeat (20) @(negedge clock);
    total_checks++;
    if (valid !== 1'b0) report("unexpected word");
  endtask

  // new mode and sync polarities take effect only after two sensor edges, sent with syncs idle; the edge invert acts at once
  task automatic setup(input logic [1:0] m, input logic f_fall, input logic l_low, input logic iv);
    @(negedge clock);
    mode    = m;
    fs_fall = f_fall;
    ls_low  = l_low;
    inv     = iv;
    repeat (2) cip_sensor_model_inst.beat(f_fall, l_low, 8'h10);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic test_reset();
    repeat (4) cip_sensor_model_inst.beat(1'b1, 1'b1, 8'h77);
    check_empty();
    total_checks++;
    if (frame_act !== 1'b0 || line_act !== 1'b0 || ovf !== 1'b0) report("state not idle after reset");
  endtask

  task automatic test_gated(input logic ff, input logic ll, input logic iv);
    logic seen;
    setup(2'b01, ff, ll, iv);
    // one idle edge more, so the new sync polarity is already the previous level
    cip_sensor_model_inst.beat(ff, ll, 8'h10);
    @(negedge clock);
    ready = 1'b0;
    cip_sensor_model_inst.beat(~ff, ~ll, 8'hA0);
    seen = 1'b0;
    repeat (8) begin
      @(negedge clock);
      seen = seen | (fpulse === 1'b1);
    end
    total_checks++;
    if (!seen || frame_act !== 1'b1 || line_act !== 1'b1) report("frame or line start not seen");
    for (int k = 1; k < 4; k++) cip_sensor_model_inst.beat(~ff, ~ll, 8'hA0 + 8'(k));
    repeat (2) cip_sensor_model_inst.beat(~ff, ll, 8'hEE);
    for (int k = 0; k < 2; k++) cip_sensor_model_inst.beat(~ff, ~ll, 8'hB0 + 8'(k));
    setup(2'b11, ff, ll, iv);
    @(negedge clock);
    ready = 1'b1;
    check(8'hA0, 1'b1);
    for (int k = 1; k < 4; k++) check(8'hA0 + 8'(k), 1'b0);
    for (int k = 0; k < 2; k++) check(8'hB0 + 8'(k), 1'b0);
    check_empty();
  endtask

  task automatic test_free();
    setup(2'b10, 1'b0, 1'b0, 1'b0);
    @(negedge clock);
    ready = 1'b0;
    for (int k = 0; k < 5; k++) cip_sensor_model_inst.beat(1'b0, k[0], 8'hC0 + 8'(k));
    setup(2'b11, 1'b0, 1'b0, 1'b0);
    @(negedge clock);
    ready = 1'b1;
    for (int k = 0; k < 5; k++) check(8'hC0 + 8'(k), 1'b0);
    repeat (2) check(8'h10, 1'b0);
    check_empty();
  endtask

  task automatic test_embedded();
    logic [7:0] s [22] = '{8'hFF, 8'h00, 8'h00, 8'hB0, 8'h10, 8'h10, 8'hFF, 8'h00, 8'h00, 8'h80, 8'h21,
                          8'h22, 8'h23, 8'hFF, 8'h00, 8'h00, 8'h90, 8'h10, 8'h10, 8'h10, 8'h10, 8'h10};
    setup(2'b00, 1'b0, 1'b0, 1'b0);
    @(negedge clock);
    ready = 1'b0;
    foreach (s[k]) cip_sensor_model_inst.beat(1'b0, 1'b0, s[k]);
    setup(2'b11, 1'b0, 1'b0, 1'b0);
    @(negedge clock);
    ready = 1'b1;
    check(8'h21, 1'b1);
    check(8'h22, 1'b0);
    check(8'h23, 1'b0);
    check_empty();
  endtask

  task automatic test_overflow();
    @(negedge clock);
    ready = 1'b0;
    setup(2'b10, 1'b0, 1'b0, 1'b0);
    for (int k = 0; k < 20; k++) cip_sensor_model_inst.beat(1'b0, 1'b0, 8'hD0 + 8'(k));
    setup(2'b11, 1'b0, 1'b0, 1'b0);
    repeat (10) @(negedge clock);
    total_checks++;
    if (ovf !== 1'b1) report("overflow not flagged");
    ready = 1'b1;
    for (int k = 0; k < 16; k++) check(8'hD0 + 8'(k), 1'b0);
    repeat (20) @(negedge clock);
    ovf_clr = 1'b1;
    @(negedge clock);
    ovf_clr = 1'b0;
    total_checks++;
    if (ovf !== 1'b0 || valid !== 1'b0) report("overflow not cleared or words left");
  endtask

  initial begin
    rst_n   = 1'b0;
    mode    = 2'b11;
    fs_fall = 1'b0;
    ls_low  = 1'b0;
    inv     = 1'b0;
    ready   = 1'b1;
    ovf_clr = 1'b0;
    repeat (10) @(posedge clock);
    repeat (2) cip_sensor_model_inst.beat(1'b0, 1'b0, 8'h33);
    repeat (9) @(posedge clock);
    @(negedge clock);
    rst_n = 1'b1;
    test_reset();
    test_gated(1'b0, 1'b0, 1'b0);
    test_gated(1'b1, 1'b1, 1'b1);
    test_free();
    test_embedded();
    test_overflow();
    end_sim();
  end
endmodule
